// ==== verilog/prs_consts.svh ====
// constants of the reference clock switchover block: offsets, fields, resets, counts
// assumes inclusion by the monitor and by every design file that decodes registers
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// ****************************************
// register offsets (byte addresses, low 12 bits decoded)
// ****************************************
`define PRS_OFS_CTRL 12'h000
`define PRS_OFS_STATUS 12'h004

// ****************************************
// control register fields
// ****************************************
`define PRS_CTRL_MODE_LSB 0
`define PRS_CTRL_MODE_MSB 1
`define PRS_CTRL_SWREQ_BIT 2
`define PRS_CTRL_PLLRST_BIT 3
`define PRS_CTRL_MODE_RST 2'h1
`define PRS_CTRL_SWREQ_RST 1'b0
`define PRS_CTRL_PLLRST_RST 1'b0

// ****************************************
// status register fields
// ****************************************
`define PRS_STAT_LOSS_PRI_BIT 0
`define PRS_STAT_LOSS_BAK_BIT 1
`define PRS_STAT_SEL_BIT 2
`define PRS_STAT_BUSY_BIT 3

// ****************************************
// response codes and counts
// ****************************************
`define PRS_RESP_OKAY 2'h0
`define PRS_RESP_SLVERR 2'h2
// three edges, so an other input up to twice as fast never flags a live one
`define PRS_LOSS_EDGES 2'h3
`define PRS_QUAL_EDGES 2'h3

`endif

// ==== verilog/prs_pkg.sv ====
// types and shared helpers of the reference clock switchover block
// assumes nothing beyond the constants header
package prs_pkg;

  // ****************************************
  // modes and sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    PRS_MODE_AUTO,
    PRS_MODE_MANUAL,
    PRS_MODE_OVERRIDE,
    PRS_MODE_SPARE
  } prs_mode_t;

  typedef enum logic [1:0] {
    PRS_SW_IDLE,
    PRS_SW_GATE_OLD,
    PRS_SW_SELECT_NEW
  } prs_state_t;

  // falling edge between two successive samples of a reference input
  function automatic logic prs_fell(input logic prev, input logic cur);
    prs_fell = prev & ~cur;
  endfunction : prs_fell

endpackage : prs_pkg

// ==== verilog/prs_clk_monitor.sv ====
// activity monitor for one reference input, timed by the other input
// assumes both inputs already sampled on aclk and edges given as one-cycle pulses
`timescale 1ns/1ps
`include "prs_consts.svh"

module prs_clk_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sampled edges
  input wire logic own_fall,
  input wire logic other_fall,
  // result
  output logic loss
);
  import prs_pkg::*;

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic loss_q;
  logic loss_d;

  // ****************************************
  // counting the other input's edges
  // ****************************************
  // both idle: no edges counted, so no new loss is claimed
  always_comb begin
    cnt_d = cnt_q;
    loss_d = loss_q;
    if (own_fall) begin
      cnt_d = 2'h0;
      loss_d = 1'b0;
    end else if (other_fall && cnt_q != `PRS_LOSS_EDGES) begin
      cnt_d = cnt_q + 2'h1;
      if (cnt_q + 2'h1 == `PRS_LOSS_EDGES) begin
        loss_d = 1'b1; // R24
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 2'h0;
      loss_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      loss_q <= loss_d;
    end
  end

  assign loss = loss_q;

endmodule : prs_clk_monitor

// ==== verilog/prs_switchover.sv ====
// reference clock switchover: selects primary or backup input for the pll
// assumes reference inputs are slow next to aclk and treated as synchronous samples
// Behaviour
// R1: auto mode leaves a stopped active input
// R2: manual: qualified request rise swaps inputs
// R3: override: high request blocks automatic switching
// R4: two loss flags and selection indicator out
// R5: auto switching repeats without count limit
// R6: both idle: no switchover started
// R7: loss flag only on sensed stop
// R8: wide frequency gap: only indicator trusted
// R9: indicator shows the current pll reference
// R10: stuck two cycles: flag, mux moves
// R11: auto switch on available input's fall
// R12: gate at old fall, select at new
// R13: override indicator follows request; no flags
// R14: only request rises switch, falls never
// R15: finish only when target input toggles
// R16: primary selected after reset
// R17: fabric drops request before next switch
// R18: request held three slower-input cycles
// R19: request raised only with both running
// R20: auto mode needs inputs within 2x
// R21: fabric pulses pll reset after switch
// R22: spread spectrum is plain jitter here
// R23: pll reset held at least 10 ns
// R24: loss sensed by other input's cycles
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "prs_consts.svh"

module prs_switchover (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reference inputs
  input wire logic ref_clock_primary,
  input wire logic ref_clock_backup,
  // pll side and status
  output logic mux_select,
  output logic gated_reference,
  output logic pll_reset,
  output logic loss_flag_primary,
  output logic loss_flag_backup,
  output logic selected_input_indicator
);
  import prs_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic pri_q, pri_d, pri_prev_q, pri_prev_d;
  logic bak_q, bak_d, bak_prev_q, bak_prev_d;
  logic pri_fall, bak_fall, loss_pri, loss_bak;
  prs_mode_t mode_q, mode_d;
  logic swreq_q, swreq_d, pllrst_q, pllrst_d;
  prs_state_t state_q, state_d;
  logic sel_q, sel_d, gate_q, gate_d;
  logic ref_out_q, ref_out_d, req_prev_q, req_prev_d;
  logic armed_q, armed_d;
  logic [1:0] qual_pri_q, qual_pri_d, qual_bak_q, qual_bak_d;
  logic old_fall, new_fall, active_loss, target_loss;
  logic manual_go, auto_go, auto_allowed;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [11:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  // ****************************************
  // sampling of the reference inputs
  // ****************************************
  always_comb begin
    pri_d = ref_clock_primary;
    bak_d = ref_clock_backup;
    pri_prev_d = pri_q;
    bak_prev_d = bak_q;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_q <= 1'b0;
      bak_q <= 1'b0;
      pri_prev_q <= 1'b0;
      bak_prev_q <= 1'b0;
    end else begin
      pri_q <= pri_d;
      bak_q <= bak_d;
      pri_prev_q <= pri_prev_d;
      bak_prev_q <= bak_prev_d;
    end
  end

  // spread input needs no special path, its wander is plain jitter here
  assign pri_fall = prs_fell(pri_prev_q, pri_q); // R22
  assign bak_fall = prs_fell(bak_prev_q, bak_q);

  // ****************************************
  // loss sensing, each input timed by the other
  // ****************************************
  prs_clk_monitor u_mon_pri (
    .aclk(aclk),
    .aresetn(aresetn),
    .own_fall(pri_fall),
    .other_fall(bak_fall),
    .loss(loss_pri)
  );
  prs_clk_monitor u_mon_bak (
    .aclk(aclk),
    .aresetn(aresetn),
    .own_fall(bak_fall),
    .other_fall(pri_fall),
    .loss(loss_bak)
  );

  // ****************************************
  // switch sequencer
  // ****************************************
  assign old_fall = sel_q ? bak_fall : pri_fall;
  assign new_fall = sel_q ? pri_fall : bak_fall;
  assign active_loss = sel_q ? loss_bak : loss_pri;
  assign target_loss = sel_q ? loss_pri : loss_bak;
  // automatic path off in manual mode and while an override request is high
  assign auto_allowed = (mode_q == PRS_MODE_AUTO) || (mode_q == PRS_MODE_OVERRIDE && !swreq_q); // R3
  // target must be alive, so a double stop never starts a switch
  assign auto_go = auto_allowed && active_loss && !target_loss; // R1 R5 R6 R10
  assign manual_go = (mode_q != PRS_MODE_AUTO) && armed_q && swreq_q &&
                     qual_pri_q == `PRS_QUAL_EDGES && qual_bak_q == `PRS_QUAL_EDGES; // R2 R18

  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    gate_d = gate_q;
    req_prev_d = swreq_q;
    armed_d = armed_q;
    qual_pri_d = qual_pri_q;
    qual_bak_d = qual_bak_q;
    // only a rise arms; a fall just disarms and never swaps back
    if (swreq_q && !req_prev_q && !loss_pri && !loss_bak) begin
      armed_d = 1'b1; // R14 R19
      qual_pri_d = 2'h0;
      qual_bak_d = 2'h0;
    end else if (!swreq_q) begin
      armed_d = 1'b0; // R14 R17
    end else begin
      if (pri_fall && qual_pri_q != `PRS_QUAL_EDGES) begin
        qual_pri_d = qual_pri_q + 2'h1;
      end
      if (bak_fall && qual_bak_q != `PRS_QUAL_EDGES) begin
        qual_bak_d = qual_bak_q + 2'h1;
      end
    end
    case (state_q)
      PRS_SW_IDLE: begin
        if (manual_go) begin
          armed_d = 1'b0;
          state_d = PRS_SW_GATE_OLD;
        end else if (auto_go) begin
          // old input is dead, gate now and finish on the live one
          gate_d = 1'b1; // R11
          state_d = PRS_SW_SELECT_NEW;
        end
      end
      PRS_SW_GATE_OLD: begin
        if (old_fall || active_loss) begin
          gate_d = 1'b1; // R12
          state_d = PRS_SW_SELECT_NEW;
        end
      end
      PRS_SW_SELECT_NEW: begin
        // waits here as long as the target is not toggling
        if (new_fall && !target_loss) begin
          sel_d = ~sel_q; // R12 R15 R11
          gate_d = 1'b0;
          state_d = PRS_SW_IDLE;
        end
      end
      default: begin
        state_d = PRS_SW_IDLE;
      end
    endcase
  end

  // glitch-free reference: low while gated, else the selected sample
  always_comb begin
    ref_out_d = 1'b0;
    if (!gate_d) begin
      ref_out_d = sel_d ? bak_q : pri_q;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= PRS_SW_IDLE;
      sel_q <= 1'b0; // R16
      gate_q <= 1'b0;
      ref_out_q <= 1'b0;
      req_prev_q <= 1'b0;
      armed_q <= 1'b0;
      qual_pri_q <= 2'h0;
      qual_bak_q <= 2'h0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      gate_q <= gate_d;
      ref_out_q <= ref_out_d;
      req_prev_q <= req_prev_d;
      armed_q <= armed_d;
      qual_pri_q <= qual_pri_d;
      qual_bak_q <= qual_bak_d;
    end
  end

  // ****************************************
  // axi4-lite write side and control register
  // ****************************************
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    mode_d = mode_q;
    swreq_d = swreq_q;
    pllrst_d = pllrst_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      waddr_d = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_hold_q && w_hold_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `PRS_RESP_OKAY;
      if (waddr_q == `PRS_OFS_CTRL) begin
        // all control fields live in byte lane 0
        if (wstrb_q[0]) begin
          mode_d = prs_mode_t'(wdata_q[`PRS_CTRL_MODE_MSB:`PRS_CTRL_MODE_LSB]);
          swreq_d = wdata_q[`PRS_CTRL_SWREQ_BIT];
          // pulse width is software's job, the block only holds the level
          pllrst_d = wdata_q[`PRS_CTRL_PLLRST_BIT]; // R21 R23
        end
      end else if (waddr_q != `PRS_OFS_STATUS) begin
        bresp_d = `PRS_RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `PRS_RESP_OKAY;
      mode_q <= prs_mode_t'(`PRS_CTRL_MODE_RST);
      swreq_q <= `PRS_CTRL_SWREQ_RST;
      pllrst_q <= `PRS_CTRL_PLLRST_RST;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      mode_q <= mode_d;
      swreq_q <= swreq_d;
      pllrst_q <= pllrst_d;
    end
  end

  // ****************************************
  // axi4-lite read side and status register
  // ****************************************
  assign s_axi_arready = !rvalid_q;
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0000_0000;
      rresp_d = `PRS_RESP_OKAY;
      if (s_axi_araddr[11:0] == `PRS_OFS_CTRL) begin
        rdata_d[`PRS_CTRL_MODE_MSB:`PRS_CTRL_MODE_LSB] = mode_q;
        rdata_d[`PRS_CTRL_SWREQ_BIT] = swreq_q;
        rdata_d[`PRS_CTRL_PLLRST_BIT] = pllrst_q;
      end else if (s_axi_araddr[11:0] == `PRS_OFS_STATUS) begin
        // flags are unreliable past a 2x gap; indicator stays exact
        rdata_d[`PRS_STAT_LOSS_PRI_BIT] = loss_pri; // R4 R8
        rdata_d[`PRS_STAT_LOSS_BAK_BIT] = loss_bak;
        rdata_d[`PRS_STAT_SEL_BIT] = sel_q;
        rdata_d[`PRS_STAT_BUSY_BIT] = (state_q != PRS_SW_IDLE);
      end else begin
        rresp_d = `PRS_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PRS_RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // flags come straight from the monitors, so a manual swap raises none
  assign loss_flag_primary = loss_pri; // R4 R7 R13
  assign loss_flag_backup = loss_bak;
  assign selected_input_indicator = sel_q; // R9 R13
  assign mux_select = sel_q; // R10
  assign gated_reference = ref_out_q;
  assign pll_reset = pllrst_q;

endmodule : prs_switchover

// ==== verif/prs_ref_source.sv ====
// two reference oscillators feeding the switchover block, each can be stopped
// assumes run controls come from the bench; periods stay within 2x of each other
`timescale 1ns/1ps

module prs_ref_source #(
  parameter int HALF_P = 203,
  parameter int HALF_B = 233
) (
  // run controls
  input wire logic run_primary,
  input wire logic run_backup,
  // reference clocks
  output logic ref_clock_primary,
  output logic ref_clock_backup
);
  // half-ns phase keeps input edges clear of aclk edges, so sampling never races
  initial begin
    ref_clock_primary = 1'b0;
    #0.5;
    forever begin
      #HALF_P;
      // a stopped oscillator parks low, the failure the sense logic must catch
      ref_clock_primary = run_primary & ~ref_clock_primary;
    end
  end

  initial begin
    ref_clock_backup = 1'b0;
    #0.5;
    forever begin
      #HALF_B;
      ref_clock_backup = run_backup & ~ref_clock_backup;
    end
  end
endmodule : prs_ref_source

// ==== verif/prs_switchover_assertions.sv ====
// concurrent checks on the ports of the reference clock switchover block
// assumes one aclk domain; bound into every prs_switchover instance
`timescale 1ns/1ps

module prs_switchover_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reference side
  input wire logic ref_clock_primary,
  input wire logic ref_clock_backup,
  input wire logic mux_select,
  input wire logic gated_reference,
  input wire logic loss_flag_primary,
  input wire logic loss_flag_backup,
  input wire logic selected_input_indicator
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_ind_tracks_mux: assert property (selected_input_indicator == mux_select)
    else $error("indicator differs from mux select");
  a_reset_primary: assert property ($rose(aresetn) |-> !mux_select && !loss_flag_primary)
    else $error("primary not selected after reset");
  // mux may only move while the pll reference is held low, else a glitch escapes
  a_sel_when_gated: assert property ($changed(mux_select) |-> $past(gated_reference) == 1'b0)
    else $error("select moved while reference ungated");
  a_loss_p_stopped: assert property ($rose(loss_flag_primary) |-> $stable(ref_clock_primary) &&
    $past(ref_clock_primary, 4) == ref_clock_primary)
    else $error("primary loss flag while toggling");
  a_loss_b_stopped: assert property ($rose(loss_flag_backup) |-> $stable(ref_clock_backup) &&
    $past(ref_clock_backup, 4) == ref_clock_backup)
    else $error("backup loss flag while toggling");
  a_flags_exclusive: assert property (!(loss_flag_primary && loss_flag_backup))
    else $error("both loss flags high");
  a_loss_p_clears: assert property (loss_flag_primary && $fell(ref_clock_primary) |-> ##[1:4] !loss_flag_primary)
    else $error("primary loss flag stuck");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  a_write_answered: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
    ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_read_answered: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");

  c_to_backup: cover property ($rose(mux_select));
  c_to_primary: cover property ($fell(mux_select));
  c_loss_primary: cover property ($rose(loss_flag_primary));
endmodule : prs_switchover_assertions

bind prs_switchover prs_switchover_assertions prs_switchover_assertions_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .ref_clock_primary,
  .ref_clock_backup, .mux_select, .gated_reference, .loss_flag_primary, .loss_flag_backup,
  .selected_input_indicator);

// ==== verif/prs_switchover_test.sv ====
// self-checking bench of the reference clock switchover block
// assumes design files and the oscillator model compiled first
`timescale 1ns/1ps

module prs_switchover_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic run_primary = 1'b1, run_backup = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic ref_clock_primary, ref_clock_backup, mux_select, gated_reference, pll_reset;
  logic loss_flag_primary, loss_flag_backup, selected_input_indicator;
  int n_mismatch = 0, n_compared = 0;

  always #20 aclk = ~aclk;

  prs_switchover prs_switchover_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_clock_primary, .ref_clock_backup,
    .mux_select, .gated_reference, .pll_reset, .loss_flag_primary, .loss_flag_backup,
    .selected_input_indicator);

  prs_ref_source prs_ref_source_inst (.run_primary, .run_backup, .ref_clock_primary, .ref_clock_backup);

  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chkb(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : chkb

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= {20'h0_0000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do
          @(posedge aclk);
        while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do
          @(posedge aclk);
        while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rdreg(input logic [11:0] a);
    s_axi_araddr <= {20'h0_0000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rdreg

  task automatic wait_sel(input logic v);
    for (int i = 0; i < 400 && mux_select !== v; i++) @(posedge aclk);
    chkb(mux_select, v);
    chkb(selected_input_indicator, v);
    // new input has just fallen, so the pll still sees a low reference
    chkb(gated_reference, 1'b0);
  endtask : wait_sel

  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset;
    rdreg(12'h000);
    chk(rd, 32'h0000_0001);
    rdreg(12'h004);
    chk(rd, 32'h0000_0000);
    rdreg(12'h008);
    chk({rs, rd[29:0]}, 32'h8000_0000);
    wr(12'h004, 32'h0000_000f);
    chk({30'h0, rs}, 32'h0000_0000);
    rdreg(12'h004);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_manual;
    wr(12'h000, 32'h0000_0005);
    wait_sel(1'b1);
    chkb(loss_flag_primary | loss_flag_backup, 1'b0);
    wr(12'h000, 32'h0000_0001);
    repeat (100) @(posedge aclk);
    chkb(mux_select, 1'b1);
    // request too short to qualify
    wr(12'h000, 32'h0000_0005);
    wr(12'h000, 32'h0000_0001);
    repeat (100) @(posedge aclk);
    chkb(mux_select, 1'b1);
    wr(12'h000, 32'h0000_0005);
    wait_sel(1'b0);
    wr(12'h000, 32'h0000_0001);
    $display("test manual done");
  endtask : t_manual

  task automatic t_auto;
    wr(12'h000, 32'h0000_0000);
    run_primary <= 1'b0;
    for (int i = 0; i < 400 && loss_flag_primary !== 1'b1; i++) @(posedge aclk);
    chkb(loss_flag_primary, 1'b1);
    wait_sel(1'b1);
    run_primary <= 1'b1;
    repeat (60) @(posedge aclk);
    chkb(loss_flag_primary, 1'b0);
    run_backup <= 1'b0;
    for (int i = 0; i < 400 && loss_flag_backup !== 1'b1; i++) @(posedge aclk);
    chkb(loss_flag_backup, 1'b1);
    wait_sel(1'b0);
    run_backup <= 1'b1;
    repeat (60) @(posedge aclk);
    chkb(loss_flag_backup, 1'b0);
    $display("test auto done");
  endtask : t_auto

  task automatic t_idle;
    run_backup <= 1'b0;
    repeat (60) @(posedge aclk);
    run_primary <= 1'b0;
    repeat (100) @(posedge aclk);
    chkb(mux_select, 1'b0);
    run_backup <= 1'b1;
    wait_sel(1'b1);
    run_primary <= 1'b1;
    repeat (60) @(posedge aclk);
    $display("test idle done");
  endtask : t_idle

  task automatic t_override;
    wr(12'h000, 32'h0000_0006);
    wait_sel(1'b0);
    run_primary <= 1'b0;
    repeat (100) @(posedge aclk);
    chkb(mux_select, 1'b0);
    wr(12'h000, 32'h0000_0002);
    wait_sel(1'b1);
    run_primary <= 1'b1;
    wr(12'h000, 32'h0000_000a);
    chkb(pll_reset, 1'b1);
    wr(12'h000, 32'h0000_0002);
    chkb(pll_reset, 1'b0);
    $display("test override done");
  endtask : t_override

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_manual;
    t_auto;
    t_idle;
    t_override;
    finish_test;
  end

  // whole run needs about a thousand cycles; ten thousand means a hang
  initial begin
    #400_000;
    n_mismatch++;
    $display("watchdog expired");
    finish_test;
  end
endmodule : prs_switchover_test
